// [design/serial_port_pkg.sv]
// constants and state types of the host serial port
`default_nettype none
package serial_port_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_HZ = 10_000_000;
    localparam int BAUD_RATE = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;
    localparam int FRAME_BITS = 10;
    localparam int FRAME_CYCLES = FRAME_BITS * BIT_CYCLES;
    localparam int CNT_W = 16;
    localparam int BITS_W = 4;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [BITS_W-1:0] LAST_BIT = 4'h7;
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : serial_port_pkg
`default_nettype wire

// [design/byte_stream_if.sv]
// valid/ready stream carrier between the receiver and its buffer
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
    logic [W-1:0] wrData;
    logic wrValid;
    logic wrReady;
    logic [W-1:0] rdData;
    logic rdValid;
    logic rdReady;
    modport buffer (input wrData, input wrValid, output wrReady,
                    output rdData, output rdValid, input rdReady);
    modport user (output wrData, output wrValid, input wrReady,
                  input rdData, input rdValid, output rdReady);
endinterface : byte_stream_if
`default_nettype wire

// [design/stream_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // stream sides
    byte_stream_if.buffer f
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [CW-1:0] count, next_count;
    logic doWrite, doRead;

    assign f.wrReady = (count != FULL);
    assign f.rdValid = (count != '0);
    assign f.rdData = mem[rdPtr];

    always_comb begin
        doWrite = f.wrValid && f.wrReady;
        doRead = f.rdValid && f.rdReady;
        next_wrPtr = doWrite ? PW'((32'(wrPtr) + 1) % DEPTH) : wrPtr;
        next_rdPtr = doRead ? PW'((32'(rdPtr) + 1) % DEPTH) : rdPtr;
        next_count = count;
        if (doWrite && !doRead) begin
            next_count = count + 1'b1;
        end else if (doRead && !doWrite) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // storage needs no reset
    always_ff @(posedge core_clk) begin
        if (doWrite) begin
            mem[wrPtr] <= f.wrData;
        end
    end

    chk_count_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
        count <= FULL) else $error("fifo count beyond depth");
endmodule : stream_fifo
`default_nettype wire

// [design/host_serial_port.sv]
// host-side asynchronous serial port with optional hardware flow control
`default_nettype none
module host_serial_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // host pins
    output logic host_tx_line,
    input wire logic host_rx_line,
    input wire logic host_clear_to_send_n,
    output logic host_ready_to_send_n,
    // configuration
    input wire logic flowCtrlEn,
    // transmit data from device logic
    input wire logic [serial_port_pkg::DATA_W-1:0] txData,
    input wire logic txValid,
    output logic txReady,
    // receive data to device logic
    output logic [serial_port_pkg::DATA_W-1:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    // receive status pulses
    output logic rxFrameErr,
    output logic rxOverrun
);
    import serial_port_pkg::*;

    // pin synchronisers
    logic rxMeta, rxSync, ctsMeta, ctsSync;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rxMeta <= LINE_IDLE;
            rxSync <= LINE_IDLE;
            ctsMeta <= 1'b1;
            ctsSync <= 1'b1;
        end else begin
            rxMeta <= host_rx_line;
            rxSync <= rxMeta;
            ctsMeta <= host_clear_to_send_n;
            ctsSync <= ctsMeta;
        end
    end

    // transmitter
    tx_state_t txState, next_txState;
    logic [CNT_W-1:0] txCnt, next_txCnt;
    logic [BITS_W-1:0] txBit, next_txBit;
    logic [DATA_W-1:0] txShift, next_txShift, txHold, next_txHold;
    logic txPend, next_txPend, next_txReady, next_txLine;
    logic txGo;

    always_comb begin
        next_txState = txState;
        next_txCnt = txCnt;
        next_txBit = txBit;
        next_txShift = txShift;
        next_txHold = txHold;
        next_txPend = txPend;
        next_txLine = host_tx_line;
        // cts is consulted only here, at the frame boundary
        txGo = txPend && (!flowCtrlEn || !ctsSync);
        if (txValid && txReady) begin
            next_txHold = txData;
            next_txPend = 1'b1;
        end
        unique case (txState)
            TX_IDLE: begin
                next_txLine = LINE_IDLE;
                if (txGo) begin
                    next_txState = TX_START;
                    next_txShift = txHold;
                    next_txPend = 1'b0;
                    next_txCnt = '0;
                    next_txLine = 1'b0;
                end
            end
            TX_START, TX_DATA: begin
                // frame runs to completion whatever cts does
                next_txCnt = txCnt + 1'b1;
                if (txCnt == BIT_LAST) begin
                    next_txCnt = '0;
                    next_txLine = txShift[0];
                    next_txShift = txShift >> 1;
                    next_txState = TX_DATA;
                    if (txState == TX_START) begin
                        next_txBit = '0;
                    end else if (txBit == LAST_BIT) begin
                        next_txState = TX_STOP;
                        next_txLine = LINE_IDLE;
                    end else begin
                        next_txBit = txBit + 1'b1;
                    end
                    if (txState == TX_DATA && txBit != LAST_BIT) begin
                        next_txLine = txShift[0];
                    end
                end
            end
            TX_STOP: begin
                next_txCnt = txCnt + 1'b1;
                if (txCnt == BIT_LAST) begin
                    next_txState = TX_IDLE;
                    next_txCnt = '0;
                end
            end
        endcase
        next_txReady = !next_txPend;
    end

    // reset clears every piece of state at once
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            txState <= TX_IDLE;
            txCnt <= '0;
            txBit <= '0;
            txShift <= '0;
            txHold <= '0;
            txPend <= 1'b0;
            txReady <= 1'b0;
            host_tx_line <= LINE_IDLE;
        end else begin
            txState <= next_txState;
            txCnt <= next_txCnt;
            txBit <= next_txBit;
            txShift <= next_txShift;
            txHold <= next_txHold;
            txPend <= next_txPend;
            txReady <= next_txReady;
            host_tx_line <= next_txLine;
        end
    end

    // receiver and its buffer
    byte_stream_if #(.W(DATA_W)) rxq ();
    rx_state_t rxState, next_rxState;
    logic [CNT_W-1:0] rxCnt, next_rxCnt;
    logic [BITS_W-1:0] rxBit, next_rxBit;
    logic [DATA_W-1:0] rxShift, next_rxShift, next_rxData;
    logic next_rxValid, next_rxFrameErr, next_rxOverrun, next_rtsN;

    stream_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .f(rxq.buffer)
    );

    assign rxq.wrData = rxShift;
    assign rxq.rdReady = !rxValid || rxReady;

    always_comb begin
        next_rxState = rxState;
        next_rxCnt = rxCnt + 1'b1;
        next_rxBit = rxBit;
        next_rxShift = rxShift;
        next_rxFrameErr = 1'b0;
        next_rxOverrun = 1'b0;
        rxq.wrValid = 1'b0;
        unique case (rxState)
            RX_IDLE: begin
                next_rxCnt = '0;
                if (!rxSync) begin
                    next_rxState = RX_START;
                end
            end
            RX_START: begin
                if (rxCnt == HALF_LAST) begin
                    next_rxCnt = '0;
                    next_rxBit = '0;
                    next_rxState = rxSync ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rxCnt == BIT_LAST) begin
                    next_rxCnt = '0;
                    next_rxShift = {rxSync, rxShift[DATA_W-1:1]};
                    next_rxBit = rxBit + 1'b1;
                    if (rxBit == LAST_BIT) begin
                        next_rxState = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rxCnt == BIT_LAST) begin
                    next_rxState = RX_IDLE;
                    next_rxCnt = '0;
                    rxq.wrValid = rxSync;
                    next_rxFrameErr = !rxSync;
                    next_rxOverrun = rxSync && !rxq.wrReady;
                end
            end
        endcase
        next_rxData = rxData;
        next_rxValid = rxValid && !rxReady;
        if (rxq.rdValid && rxq.rdReady) begin
            next_rxData = rxq.rdData;
            next_rxValid = 1'b1;
        end
        // busy while the buffer is full; inactive high without flow control
        next_rtsN = !(flowCtrlEn && rxq.wrReady);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rxState <= RX_IDLE;
            rxCnt <= '0;
            rxBit <= '0;
            rxShift <= '0;
            rxData <= '0;
            rxValid <= 1'b0;
            rxFrameErr <= 1'b0;
            rxOverrun <= 1'b0;
            host_ready_to_send_n <= 1'b1;
        end else begin
            rxState <= next_rxState;
            rxCnt <= next_rxCnt;
            rxBit <= next_rxBit;
            rxShift <= next_rxShift;
            rxData <= next_rxData;
            rxValid <= next_rxValid;
            rxFrameErr <= next_rxFrameErr;
            rxOverrun <= next_rxOverrun;
            host_ready_to_send_n <= next_rtsN;
        end
    end

    // frame length helper
    logic [CNT_W-1:0] busyCnt;
    always_ff @(posedge core_clk) begin
        if (!reset_n || txState == TX_IDLE) begin
            busyCnt <= '0;
        end else begin
            busyCnt <= busyCnt + 1'b1;
        end
    end

    chk_start_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
        (txState == TX_IDLE ##1 txState == TX_START) |-> $past(!flowCtrlEn || !ctsSync))
        else $error("frame started while clear-to-send high");
    chk_cts_ignored: assert property (@(posedge core_clk) disable iff (!reset_n)
        (txState == TX_IDLE && txPend && !flowCtrlEn) |=> txState == TX_START)
        else $error("frame held back with flow control off");
    chk_frame_whole: assert property (@(posedge core_clk) disable iff (!reset_n)
        (txState == TX_STOP && txCnt == BIT_LAST) |-> busyCnt == CNT_W'(FRAME_CYCLES - 1))
        else $error("frame cut short");
    chk_start_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
        (txState == TX_IDLE ##1 txState == TX_START) |=> !host_tx_line [*8])
        else $error("start bit not low");
    chk_idle_line: assert property (@(posedge core_clk) disable iff (!reset_n)
        $past(txState) == TX_IDLE && txState == TX_IDLE |-> host_tx_line)
        else $error("idle line not high");
    chk_rts_off: assert property (@(posedge core_clk) disable iff (!reset_n)
        !flowCtrlEn |=> host_ready_to_send_n)
        else $error("ready-to-send active without flow control");
    chk_rts_ready: assert property (@(posedge core_clk) disable iff (!reset_n)
        (flowCtrlEn && rxq.wrReady) |=> !host_ready_to_send_n)
        else $error("ready-to-send high with room");
    chk_rts_busy: assert property (@(posedge core_clk) disable iff (!reset_n)
        (flowCtrlEn && !rxq.wrReady) |=> host_ready_to_send_n)
        else $error("ready-to-send low while full");
    chk_rx_push: assert property (@(posedge core_clk) disable iff (!reset_n)
        rxq.wrValid |-> rxState == RX_STOP && rxCnt == BIT_LAST && rxSync)
        else $error("byte pushed outside stop bit");
    chk_reset_clear: assert property (@(posedge core_clk)
        !reset_n |=> txState == TX_IDLE && host_tx_line && host_ready_to_send_n && !rxValid)
        else $error("reset left state behind");
endmodule : host_serial_port
`default_nettype wire

// [dv/host_uart_model.sv]
// behavioural host processor on the far side of the serial port
`default_nettype none
module host_uart_model
    import serial_port_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // pins seen from the host
    input wire logic host_tx_line,
    input wire logic host_ready_to_send_n,
    input wire logic flowCtrlEn,
    output logic host_rx_line,
    output logic host_clear_to_send_n
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [DATA_W-1:0] gotQ[$];
    logic [DATA_W-1:0] shift;
    int waitCount;

    initial begin
        host_rx_line = LINE_IDLE;
        host_clear_to_send_n = 1'b0;
    end

    // mid-bit sampling of frames from the device; bad stop bits are not queued
    always begin
        @(negedge host_tx_line);
        repeat (HALF_CYCLES) @(negedge core_clk);
        if (host_tx_line === 1'b0 && reset_n === 1'b1) begin
            for (int i = 0; i < DATA_W; i++) begin
                repeat (BIT_CYCLES) @(negedge core_clk);
                shift[i] = host_tx_line;
            end
            repeat (BIT_CYCLES) @(negedge core_clk);
            if (host_tx_line === LINE_IDLE) gotQ.push_back(shift);
        end
    end

    task automatic setCts(input logic v);
        @(negedge core_clk);
        host_clear_to_send_n = v;
    endtask : setCts

    // free-running 4 MHz square wave on the shared clear-to-send pin, off the clock edges
    task automatic driveRefClock(input int halfPeriods);
        @(negedge core_clk);
        #10;
        repeat (halfPeriods) begin
            host_clear_to_send_n = ~host_clear_to_send_n;
            #125;
        end
    endtask : driveRefClock

    // one 8N1 frame, lsb first, held back while the device is busy and flow control is on; a low stop makes it bad
    task automatic sendByte(input logic [DATA_W-1:0] b, input logic stopLevel);
        logic [FRAME_BITS-1:0] frame;
        frame = {stopLevel, b, 1'b0};
        waitCount = 0;
        @(negedge core_clk);
        while (flowCtrlEn && host_ready_to_send_n !== 1'b0 && waitCount < 5000) begin
            @(negedge core_clk);
            waitCount++;
        end
        for (int i = 0; i < FRAME_BITS; i++) begin
            host_rx_line = frame[i];
            repeat (BIT_CYCLES) @(negedge core_clk);
        end
        host_rx_line = LINE_IDLE;
    endtask : sendByte
endmodule : host_uart_model
`default_nettype wire

// [dv/host_serial_port_test.sv]
// self-checking bench of the host serial port against a host model
`default_nettype none
module host_serial_port_test
    import serial_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk, reset_n, flowCtrlEn, txValid, txReady, rxValid, rxReady;
    logic host_tx_line, host_rx_line, host_clear_to_send_n, host_ready_to_send_n;
    logic [DATA_W-1:0] txData, rxData;
    logic rxFrameErr, rxOverrun;
    int frameErrs = 0;
    int overruns = 0;
    int mismatches = 0;
    int checkCount = 0;
    int cycles = 0;

    host_serial_port i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .host_tx_line(host_tx_line), .host_rx_line(host_rx_line),
        .host_clear_to_send_n(host_clear_to_send_n),
        .host_ready_to_send_n(host_ready_to_send_n), .flowCtrlEn(flowCtrlEn),
        .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData),
        .rxValid(rxValid), .rxReady(rxReady), .rxFrameErr(rxFrameErr),
        .rxOverrun(rxOverrun));

    host_uart_model i_host (.core_clk(core_clk), .reset_n(reset_n),
        .host_tx_line(host_tx_line), .host_ready_to_send_n(host_ready_to_send_n),
        .flowCtrlEn(flowCtrlEn), .host_rx_line(host_rx_line),
        .host_clear_to_send_n(host_clear_to_send_n));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // receive fault pulses are counted mid-cycle; hangs end the run
    always @(negedge core_clk) begin
        if (rxFrameErr === 1'b1) frameErrs++;
        if (rxOverrun === 1'b1) overruns++;
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic checkLevel(input string what, input logic exp, input logic got);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : checkLevel

    task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : checkByte

    task automatic waitCycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask : waitCycles

    task automatic putTx(input logic [DATA_W-1:0] b);
        int n;
        n = 0;
        @(negedge core_clk);
        txData = b;
        txValid = 1'b1;
        while (txReady !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        checkLevel("txAccepted", 1'b1, txReady);
        // the rising edge before this one takes the byte
        @(negedge core_clk);
        txValid = 1'b0;
    endtask : putTx

    task automatic expectHost(input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        while (i_host.gotQ.size() == 0 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        if (i_host.gotQ.size() == 0) checkLevel("hostGotByte", 1'b1, 1'b0);
        else checkByte("hostByte", exp, i_host.gotQ.pop_front());
    endtask : expectHost

    task automatic getRx(input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        @(negedge core_clk);
        rxReady = 1'b1;
        while (rxValid !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        checkLevel("rxValid", 1'b1, rxValid);
        checkByte("rxData", exp, rxData);
        @(negedge core_clk);
        rxReady = 1'b0;
    endtask : getRx

    task automatic testTxNoFlow();
        i_host.setCts(1'b1);
        putTx(8'ha5);
        putTx(8'h5a);
        expectHost(8'ha5);
        expectHost(8'h5a);
        checkLevel("rtsFlowOff", 1'b1, host_ready_to_send_n);
    endtask : testTxNoFlow

    task automatic testRefClockOnCts();
        fork
            i_host.driveRefClock(800);
            begin
                putTx(8'h96);
                expectHost(8'h96);
            end
        join
        waitCycles(4);
        checkLevel("rtsRefClock", 1'b1, host_ready_to_send_n);
    endtask : testRefClockOnCts

    task automatic testTxCtsGate();
        logic lowSeen;
        int n;
        lowSeen = 1'b0;
        n = 0;
        flowCtrlEn = 1'b1;
        putTx(8'hc3);
        repeat (1500) begin
            @(negedge core_clk);
            if (host_tx_line !== 1'b1) lowSeen = 1'b1;
        end
        checkLevel("heldByCts", 1'b0, lowSeen);
        i_host.setCts(1'b0);
        while (host_tx_line !== 1'b0 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        checkLevel("startOnCts", 1'b0, host_tx_line);
        waitCycles(300);
        i_host.setCts(1'b1);
        expectHost(8'hc3);
    endtask : testTxCtsGate

    task automatic testRxPacing();
        rxReady = 1'b0;
        waitCycles(4);
        checkLevel("rtsReady", 1'b0, host_ready_to_send_n);
        for (int i = 0; i < 5; i++) begin
            i_host.sendByte(8'h30 + 8'(i), 1'b1);
            checkLevel("rtsWaitBounded", 1'b1, i_host.waitCount < 5000);
        end
        waitCycles(4);
        checkLevel("rtsFull", 1'b1, host_ready_to_send_n);
        for (int i = 0; i < 5; i++) getRx(8'h30 + 8'(i));
        waitCycles(4);
        checkLevel("rtsDrained", 1'b0, host_ready_to_send_n);
        checkByte("rxFaults", 8'h00, 8'(frameErrs + overruns));
        flowCtrlEn = 1'b0;
        waitCycles(4);
        checkLevel("rtsDisabled", 1'b1, host_ready_to_send_n);
    endtask : testRxPacing

    // bad stop bit, then one byte more than the buffer and output register hold
    task automatic testRxFaults();
        i_host.sendByte(8'h55, 1'b0);
        waitCycles(200);
        checkByte("frameErrs", 8'h01, 8'(frameErrs));
        checkLevel("badDropped", 1'b0, rxValid);
        for (int i = 0; i < 6; i++) i_host.sendByte(8'h40 + 8'(i), 1'b1);
        checkByte("overruns", 8'h01, 8'(overruns));
        for (int i = 0; i < 5; i++) getRx(8'h40 + 8'(i));
        waitCycles(2);
        checkLevel("rxDrained", 1'b0, rxValid);
    endtask : testRxFaults

    task automatic testResetMidFrame();
        putTx(8'h00);
        waitCycles(300);
        reset_n = 1'b0;
        waitCycles(3);
        checkLevel("txLineInReset", 1'b1, host_tx_line);
        checkLevel("txReadyInReset", 1'b0, txReady);
        reset_n = 1'b1;
        waitCycles(3);
        checkLevel("txLineAfter", 1'b1, host_tx_line);
        checkLevel("txReadyAfter", 1'b1, txReady);
    endtask : testResetMidFrame

    initial begin
        reset_n = 1'b0;
        flowCtrlEn = 1'b0;
        txData = 8'h00;
        txValid = 1'b0;
        rxReady = 1'b0;
        waitCycles(3);
        checkLevel("startTxLine", 1'b1, host_tx_line);
        checkLevel("startRts", 1'b1, host_ready_to_send_n);
        reset_n = 1'b1;
        waitCycles(4);
        testTxNoFlow();
        testRefClockOnCts();
        testTxCtsGate();
        testRxPacing();
        testRxFaults();
        testResetMidFrame();
        checkByte("rxFaultTotal", 8'h02, 8'(frameErrs + overruns));
        results();
    end
endmodule : host_serial_port_test
`default_nettype wire
